// file: core/pch_header_regs.sv
`timescale 1ns/100ps
`include "pch_regs.svh"
module pch_header_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Mode
  input wire logic endpoint_mode,
  // Internal register access
  input wire pch_pkg::pch_req_s req,
  output logic [31:0] rdata,
  output logic ack,
  output logic refused,
  // Configuration-space read port
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  output logic [31:0] cfg_rdata,
  // EEPROM preload
  input wire logic load_en,
  input wire pch_pkg::pch_load_s load,
  // PCI initiator events, PCI clock domain
  input wire pch_pkg::pch_init_s init_bus,
  // Initiator error indications and I/O base high byte
  output logic xact_error,
  output logic [7:0] io_base_hi,
  output logic [1:0] timeout_flags
);
  logic [23:0] io_base_reg;
  logic [31:0] subsys_reg;
  logic [7:0] max_lat_reg;
  logic [7:0] min_gnt_reg;
  logic [7:0] int_pin_reg;
  logic [7:0] int_line_reg;
  logic [7:0] retry_lim_reg;
  logic [7:0] ready_lim_reg;
  logic [1:0] flag_reg;
  logic [4:0] sync_q;
  logic pci_clk_d_reg;
  logic pci_rise;
  logic retry_to;
  logic ready_to;
  logic blocked;
  logic [31:0] rd_next;

  // Address decode to register value
  function automatic logic [31:0] reg_value(input logic [15:0] a, input logic [23:0] iob,
      input logic [31:0] ss, input logic [31:0] c2, input logic [15:0] tl,
      input logic [1:0] fl);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == `PCH_OFF_IO_BASE) begin
      v = {iob, 7'h00, `PCH_IO_FLAG};
    end else if (a == `PCH_OFF_SUBSYS) begin
      v = ss;
    end else if (a == `PCH_OFF_FIRST_CAPABILITY_OFFSET) begin
      v = {24'h00_0000, `PCH_CAP_OFFSET};
    end else if (a == `PCH_OFF_CFG2) begin
      v = c2;
    end else if (a == `PCH_OFF_TOLIM) begin
      v = {16'h0000, tl};
    end else if (a == `PCH_OFF_TOSTAT) begin
      v = {30'h0000_0000, fl};
    end
    return v;
  endfunction : reg_value

  function automatic logic is_blocked(input logic [15:0] a);
    return (a == `PCH_OFF_SUBSYS) || (a == `PCH_OFF_CFG2) || (a == `PCH_OFF_TOLIM);
  endfunction : is_blocked

  assign blocked = endpoint_mode && is_blocked(req.addr);

  // PCI side synchroniser
  pch_sync #(
    .W(5)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .d_async(init_bus),
    .q(sync_q)
  );

  // PCI clock edge detect
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pci_clk_d_reg <= 1'b0;
    end else begin
      pci_clk_d_reg <= sync_q[4];
    end
  end
  assign pci_rise = sync_q[4] && !pci_clk_d_reg;

  // Watchdogs
  pch_timeout u_to (
    .ref_clk(ref_clk),
    .srst(srst),
    .retry_limit(retry_lim_reg),
    .ready_wait_limit(ready_lim_reg),
    .pci_rise(pci_rise),
    .data_phase(sync_q[3]),
    .trdy_n(sync_q[2]),
    .retry(sync_q[1]),
    .xact_end(sync_q[0]),
    .retry_to(retry_to),
    .ready_to(ready_to)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      io_base_reg <= `PCH_RST_IOBASE;
    end else if (req.wr && req.addr == `PCH_OFF_IO_BASE) begin
      io_base_reg <= req.wdata[31:8];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      subsys_reg <= `PCH_RST_SUBSYS;
      max_lat_reg <= `PCH_RST_MAXLAT;
      min_gnt_reg <= `PCH_RST_MINGNT;
      int_pin_reg <= `PCH_RST_INTPIN;
    end else if (load_en) begin
      subsys_reg <= load.subsys;
      max_lat_reg <= load.max_lat;
      min_gnt_reg <= load.min_gnt;
      int_pin_reg <= load.int_pin;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      int_line_reg <= `PCH_RST_INTLINE;
    end else if (req.wr && !blocked && req.addr == `PCH_OFF_CFG2) begin
      int_line_reg <= req.wdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      retry_lim_reg <= `PCH_RST_RETRY;
      ready_lim_reg <= `PCH_RST_READY;
    end else if (req.wr && !blocked && req.addr == `PCH_OFF_TOLIM) begin
      retry_lim_reg <= req.wdata[15:8];
      ready_lim_reg <= req.wdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flag_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == `PCH_ST_READY_BIT && ready_to) || (i == `PCH_ST_RETRY_BIT && retry_to)) begin
          flag_reg[i] <= 1'b1;
        end else if (req.wr && req.addr == `PCH_OFF_TOSTAT && req.wdata[i]) begin
          flag_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Internal read path
  always_comb begin
    rd_next = reg_value(req.addr, io_base_reg, subsys_reg,
        {max_lat_reg, min_gnt_reg, int_pin_reg, int_line_reg},
        {retry_lim_reg, ready_lim_reg}, flag_reg);
  end

  // Registered answer, one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata <= 32'h0000_0000;
      ack <= 1'b0;
      refused <= 1'b0;
    end else begin
      ack <= (req.rd || req.wr) && !blocked;
      refused <= (req.rd || req.wr) && blocked;
      rdata <= (req.rd && !blocked) ? rd_next : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (cfg_rd) begin
      if (cfg_addr == `PCH_CFG_IO_BASE) begin
        cfg_rdata <= reg_value(`PCH_OFF_IO_BASE, io_base_reg, subsys_reg, 32'h0, 16'h0, 2'b0);
      end else if (cfg_addr == `PCH_CFG_SUBSYS) begin
        cfg_rdata <= subsys_reg;
      end else if (cfg_addr == `PCH_CFG_FIRST_CAPABILITY_OFFSET) begin
        cfg_rdata <= {24'h00_0000, `PCH_CAP_OFFSET};
      end else if (cfg_addr == `PCH_CFG_CFG2) begin
        cfg_rdata <= {max_lat_reg, min_gnt_reg, int_pin_reg, int_line_reg};
      end else begin
        cfg_rdata <= 32'h0000_0000;
      end
    end
  end

  // Error outputs and I/O base high byte
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      xact_error <= 1'b0;
    end else begin
      xact_error <= retry_to || ready_to;
    end
  end
  assign io_base_hi = io_base_reg[23:16];
  assign timeout_flags = flag_reg;

  // Assertions
  // io flag fixed
  AST_IO_FLAG: assert property (@(posedge ref_clk) disable iff (srst)
    req.rd && req.addr == `PCH_OFF_IO_BASE |=> ack && rdata[0] == 1'b1)
    else $error("io flag not one");
  AST_IO_RESERVED: assert property (@(posedge ref_clk) disable iff (srst)
    req.rd && req.addr == `PCH_OFF_IO_BASE |=> rdata[7:1] == 7'h00)
    else $error("io reserved bits not zero");
  AST_IO_WRITE: assert property (@(posedge ref_clk) disable iff (srst)
    req.wr && req.addr == `PCH_OFF_IO_BASE |=> io_base_reg == $past(req.wdata[31:8]))
    else $error("io base not written");
  AST_CFG_IO_BASE: assert property (@(posedge ref_clk) disable iff (srst)
    cfg_rd && cfg_addr == `PCH_CFG_IO_BASE |=>
    cfg_rdata[31:8] == $past(io_base_reg) && cfg_rdata[0] == 1'b1)
    else $error("configuration io base wrong");
  AST_REFUSE: assert property (@(posedge ref_clk) disable iff (srst)
    (req.rd || req.wr) && endpoint_mode && req.addr == `PCH_OFF_TOLIM |=> refused && !ack)
    else $error("endpoint access not refused");
  AST_REFUSE_SUBSYS: assert property (@(posedge ref_clk) disable iff (srst)
    (req.rd || req.wr) && endpoint_mode && req.addr == `PCH_OFF_SUBSYS |=>
    refused && !ack && rdata == 32'h0000_0000)
    else $error("subsystem access not refused");
  AST_REFUSE_CFG2: assert property (@(posedge ref_clk) disable iff (srst)
    (req.rd || req.wr) && endpoint_mode && req.addr == `PCH_OFF_CFG2 |=>
    refused && !ack && rdata == 32'h0000_0000)
    else $error("config two access not refused");
  AST_REFUSE_KEEP: assert property (@(posedge ref_clk) disable iff (srst)
    req.wr && endpoint_mode && req.addr == `PCH_OFF_TOLIM |=>
    retry_lim_reg == $past(retry_lim_reg) && ready_lim_reg == $past(ready_lim_reg))
    else $error("refused write changed limits");
  AST_ACK_EXCL: assert property (@(posedge ref_clk) disable iff (srst)
    !(ack && refused))
    else $error("ack and refused together");
  AST_SUBSYS_RO: assert property (@(posedge ref_clk) disable iff (srst)
    !load_en |=> subsys_reg == $past(subsys_reg))
    else $error("subsystem changed without load");
  AST_SUBSYS_CFG: assert property (@(posedge ref_clk) disable iff (srst)
    cfg_rd && cfg_addr == `PCH_CFG_SUBSYS |=> cfg_rdata == $past(subsys_reg))
    else $error("configuration subsystem wrong");
  AST_CFG2_RO: assert property (@(posedge ref_clk) disable iff (srst)
    !load_en |=> max_lat_reg == $past(max_lat_reg) && int_pin_reg == $past(int_pin_reg))
    else $error("read only field changed");
  AST_MINGNT_RO: assert property (@(posedge ref_clk) disable iff (srst)
    !load_en |=> min_gnt_reg == $past(min_gnt_reg))
    else $error("min grant changed without load");
  AST_LOAD: assert property (@(posedge ref_clk) disable iff (srst)
    load_en |=> subsys_reg == $past(load.subsys) && max_lat_reg == $past(load.max_lat))
    else $error("preload not taken");
  AST_RESET_CFG2: assert property (@(posedge ref_clk)
    srst |=> max_lat_reg == `PCH_RST_MAXLAT && min_gnt_reg == `PCH_RST_MINGNT &&
    int_pin_reg == `PCH_RST_INTPIN && int_line_reg == `PCH_RST_INTLINE)
    else $error("config two reset value wrong");
  AST_RESET_LIMITS: assert property (@(posedge ref_clk)
    srst |=> retry_lim_reg == `PCH_RST_RETRY && ready_lim_reg == `PCH_RST_READY &&
    subsys_reg == `PCH_RST_SUBSYS && flag_reg == 2'b00)
    else $error("limit reset value wrong");
  AST_INTLINE_WRITE: assert property (@(posedge ref_clk) disable iff (srst)
    req.wr && !endpoint_mode && req.addr == `PCH_OFF_CFG2 |=>
    int_line_reg == $past(req.wdata[7:0]))
    else $error("interrupt line not written");
  AST_LIMIT_WRITE: assert property (@(posedge ref_clk) disable iff (srst)
    req.wr && !endpoint_mode && req.addr == `PCH_OFF_TOLIM |=>
    {retry_lim_reg, ready_lim_reg} == $past(req.wdata[15:0]))
    else $error("limits not written");
  AST_FIRST_CAPABILITY_OFFSET: assert property (@(posedge ref_clk) disable iff (srst)
    cfg_rd && cfg_addr == `PCH_CFG_FIRST_CAPABILITY_OFFSET |=> cfg_rdata == 32'h0000_00DC)
    else $error("capability pointer wrong");
  AST_READY_FLAG: assert property (@(posedge ref_clk) disable iff (srst)
    ready_to |=> flag_reg[`PCH_ST_READY_BIT] && xact_error)
    else $error("ready flag not set");
  AST_CLEAR_READY: assert property (@(posedge ref_clk) disable iff (srst)
    req.wr && req.addr == `PCH_OFF_TOSTAT && req.wdata[`PCH_ST_READY_BIT] && !ready_to |=>
    !flag_reg[`PCH_ST_READY_BIT])
    else $error("ready flag not cleared");
  AST_STICKY_READY: assert property (@(posedge ref_clk) disable iff (srst)
    flag_reg[`PCH_ST_READY_BIT] &&
    !(req.wr && req.addr == `PCH_OFF_TOSTAT && req.wdata[`PCH_ST_READY_BIT]) |=>
    flag_reg[`PCH_ST_READY_BIT])
    else $error("ready flag lost");
  AST_RETRY_FLAG: assert property (@(posedge ref_clk) disable iff (srst)
    retry_to |=> flag_reg[`PCH_ST_RETRY_BIT] && xact_error)
    else $error("retry flag not set");
  AST_CLEAR_RETRY: assert property (@(posedge ref_clk) disable iff (srst)
    req.wr && req.addr == `PCH_OFF_TOSTAT && req.wdata[`PCH_ST_RETRY_BIT] && !retry_to |=>
    !flag_reg[`PCH_ST_RETRY_BIT])
    else $error("retry flag not cleared");
  AST_STICKY_RETRY: assert property (@(posedge ref_clk) disable iff (srst)
    flag_reg[`PCH_ST_RETRY_BIT] &&
    !(req.wr && req.addr == `PCH_OFF_TOSTAT && req.wdata[`PCH_ST_RETRY_BIT]) |=>
    flag_reg[`PCH_ST_RETRY_BIT])
    else $error("retry flag lost");
  AST_ZERO_LIMIT: assert property (@(posedge ref_clk) disable iff (srst)
    ready_lim_reg == 8'h00 && retry_lim_reg == 8'h00 |=> !ready_to && !retry_to)
    else $error("timeout with zero limit");

  // Cover points
  COV_READY_TO: cover property (@(posedge ref_clk) disable iff (srst) ready_to);
  COV_RETRY_TO: cover property (@(posedge ref_clk) disable iff (srst) retry_to);
  COV_REFUSE: cover property (@(posedge ref_clk) disable iff (srst) refused);
  COV_LOAD: cover property (@(posedge ref_clk) disable iff (srst) load_en);
  COV_FLAG_CLEAR: cover property (@(posedge ref_clk) disable iff (srst)
    req.wr && req.addr == `PCH_OFF_TOSTAT && flag_reg != 2'b00);
endmodule : pch_header_regs

// file: core/pch_regs.svh
`ifndef PCH_REGS_SVH
`define PCH_REGS_SVH
// Internal register offsets
`define PCH_OFF_IO_BASE 16'hD024
`define PCH_OFF_SUBSYS 16'hD02C
`define PCH_OFF_FIRST_CAPABILITY_OFFSET 16'hD034
`define PCH_OFF_CFG2 16'hD03C
`define PCH_OFF_TOLIM 16'hD040
`define PCH_OFF_TOSTAT 16'hD080
// Configuration-space offsets
`define PCH_CFG_IO_BASE 8'h24
`define PCH_CFG_SUBSYS 8'h2C
`define PCH_CFG_FIRST_CAPABILITY_OFFSET 8'h34
`define PCH_CFG_CFG2 8'h3C
// Fixed values and resets
`define PCH_IO_FLAG 1'b1
`define PCH_CAP_OFFSET 8'hDC
`define PCH_RST_MAXLAT 8'h0A
`define PCH_RST_MINGNT 8'h02
`define PCH_RST_INTPIN 8'h01
`define PCH_RST_INTLINE 8'h00
`define PCH_RST_SUBSYS 32'h0000_0000
`define PCH_RST_RETRY 8'h80
`define PCH_RST_READY 8'h80
`define PCH_RST_IOBASE 24'h00_0000
// Status bit positions
`define PCH_ST_RETRY_BIT 0
`define PCH_ST_READY_BIT 1
`endif

// file: core/pch_pkg.sv
package pch_pkg;
  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } pch_req_s;
  // EEPROM preload word
  typedef struct packed {
    logic [31:0] subsys;
    logic [7:0] max_lat;
    logic [7:0] min_gnt;
    logic [7:0] int_pin;
  } pch_load_s;
  // Initiator bus events, PCI clock domain
  typedef struct packed {
    logic pci_clk;
    logic data_phase;
    logic trdy_n;
    logic retry;
    logic xact_end;
  } pch_init_s;
  typedef enum logic [1:0] {
    PCH_IDLE = 2'b00,
    PCH_WAIT = 2'b01,
    PCH_DONE = 2'b10
  } pch_phase_e;
endpackage : pch_pkg

// file: core/pch_sync.sv
`timescale 1ns/100ps
// Three-stage synchroniser; change accepted when stages two and three agree
module pch_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Data
  input wire logic [W-1:0] d_async,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  // Shift chain
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // Filtered output
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule : pch_sync

// file: core/pch_timeout.sv
`timescale 1ns/100ps
// Initiator retry and ready-wait watchdogs, counted on PCI clock edges
module pch_timeout (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Limits
  input wire logic [7:0] retry_limit,
  input wire logic [7:0] ready_wait_limit,
  // Synchronised bus events and PCI clock rising edge
  input wire logic pci_rise,
  input wire logic data_phase,
  input wire logic trdy_n,
  input wire logic retry,
  input wire logic xact_end,
  // Timeout pulses
  output logic retry_to,
  output logic ready_to
);
  logic [8:0] retry_cnt_reg;
  logic [8:0] wait_cnt_reg;
  pch_pkg::pch_phase_e ph_reg;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      retry_cnt_reg <= '0;
      retry_to <= 1'b0;
    end else begin
      retry_to <= 1'b0;
      if (pci_rise) begin
        if (xact_end && !retry) begin
          retry_cnt_reg <= '0;
        end else if (retry) begin
          if (retry_limit != 8'h00 && retry_cnt_reg >= {1'b0, retry_limit}) begin
            retry_to <= 1'b1;
            retry_cnt_reg <= '0;
          end else begin
            retry_cnt_reg <= retry_cnt_reg + 9'h001;
          end
        end
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ph_reg <= pch_pkg::PCH_IDLE;
      wait_cnt_reg <= '0;
      ready_to <= 1'b0;
    end else begin
      ready_to <= 1'b0;
      if (pci_rise) begin
        case (ph_reg)
          pch_pkg::PCH_IDLE: begin
            wait_cnt_reg <= '0;
            if (data_phase && trdy_n) begin
              ph_reg <= pch_pkg::PCH_WAIT;
              wait_cnt_reg <= 9'h001;
            end
          end
          pch_pkg::PCH_WAIT: begin
            if (!trdy_n || xact_end || !data_phase) begin
              ph_reg <= pch_pkg::PCH_IDLE;
              wait_cnt_reg <= '0;
            end else if (ready_wait_limit != 8'h00 &&
                         wait_cnt_reg >= {1'b0, ready_wait_limit}) begin
              ready_to <= 1'b1;
              ph_reg <= pch_pkg::PCH_DONE;
            end else begin
              wait_cnt_reg <= wait_cnt_reg + 9'h001;
            end
          end
          pch_pkg::PCH_DONE: begin
            if (xact_end || !data_phase) begin
              ph_reg <= pch_pkg::PCH_IDLE;
              wait_cnt_reg <= '0;
            end
          end
          default: begin
            ph_reg <= pch_pkg::PCH_IDLE;
          end
        endcase
      end
    end
  end
endmodule : pch_timeout

// file: verif/pch_pci_agent.sv
`timescale 1ns/100ps
// Behavioural PCI initiator-side event source; clock stands still outside frames
module pch_pci_agent (
  // Bus events toward the block
  output pch_pkg::pch_init_s bus
);
  // Idle bus: ready pulled up, clock parked low
  initial begin
    bus = '{pci_clk: 1'b0, data_phase: 1'b0, trdy_n: 1'b1, retry: 1'b0, xact_end: 1'b0};
  end

  // One PCI clock of 400 ns; events change while the clock is low
  task automatic tick();
    #200 bus.pci_clk = 1'b1;
    #200 bus.pci_clk = 1'b0;
  endtask : tick

  // One transaction: retry terminations, then a data phase with delayed ready
  task automatic frame(input int n_retry, input int n_wait);
    int i;
    #7;
    for (i = 0; i < n_retry; i++) begin
      bus.retry = 1'b1;
      tick();
    end
    bus.retry = 1'b0;
    bus.data_phase = 1'b1;
    for (i = 0; i < n_wait; i++) begin
      tick();
    end
    bus.trdy_n = 1'b0;
    tick();
    bus.trdy_n = 1'b1;
    bus.data_phase = 1'b0;
    bus.xact_end = 1'b1;
    tick();
    bus.xact_end = 1'b0;
  endtask : frame
endmodule : pch_pci_agent

// file: verif/tb_pch_header_regs.sv
`timescale 1ns/100ps
module tb_pch_header_regs;
  logic ref_clk;
  logic srst;
  logic endpoint_mode;
  pch_pkg::pch_req_s req;
  logic [31:0] rdata;
  logic ack;
  logic refused;
  logic cfg_rd;
  logic [7:0] cfg_addr;
  logic [31:0] cfg_rdata;
  logic load_en;
  pch_pkg::pch_load_s load;
  pch_pkg::pch_init_s init_bus;
  logic xact_error;
  logic [7:0] io_base_hi;
  logic [1:0] timeout_flags;
  int n_mismatch = 0;
  int compares = 0;
  int n_err = 0;
  int i;

  // 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  pch_header_regs u_dut (
    .ref_clk(ref_clk), .srst(srst), .endpoint_mode(endpoint_mode),
    .req(req), .rdata(rdata), .ack(ack), .refused(refused),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
    .load_en(load_en), .load(load), .init_bus(init_bus),
    .xact_error(xact_error), .io_base_hi(io_base_hi), .timeout_flags(timeout_flags)
  );

  pch_pci_agent u_pci (
    .bus(init_bus)
  );

  // Count error pulses
  always @(posedge ref_clk) begin
    if (xact_error === 1'b1) n_err++;
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic note(input string s);
    $display("test %s ended, mismatches %0d", s, n_mismatch);
  endtask : note

  // One access; answer sampled mid answer cycle, st is {refused, ack}
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] wd,
                     input logic [1:0] st, input logic [31:0] exp);
    @(posedge ref_clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: wd};
    @(posedge ref_clk);
    req <= '0;
    @(negedge ref_clk);
    chk($sformatf("status %h", a), {30'h0, st}, {30'h0, refused, ack});
    if (!w) chk($sformatf("rdata %h", a), exp, rdata);
  endtask : acc

  task automatic wreg(input logic [15:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 2'b01, 32'h0);
  endtask : wreg

  task automatic rreg(input logic [15:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, 2'b01, e);
  endtask : rreg

  task automatic cfg(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    @(negedge ref_clk);
    chk("cfg_rdata", e, cfg_rdata);
  endtask : cfg

  task automatic eeprom(input logic [31:0] s, input logic [7:0] m, input logic [7:0] g,
                        input logic [7:0] p);
    @(posedge ref_clk);
    load_en <= 1'b1;
    load <= '{subsys: s, max_lat: m, min_gnt: g, int_pin: p};
    @(posedge ref_clk);
    load_en <= 1'b0;
  endtask : eeprom

  // One bus transaction, then error count and sticky flags
  task automatic frame(input int nr, input int nw, input logic [1:0] fl, input int ne);
    u_pci.frame(nr, nw);
    repeat (12) @(posedge ref_clk);
    chk("error pulses", ne, n_err);
    chk("timeout_flags", {30'h0, fl}, {30'h0, timeout_flags});
    rreg(16'hD080, {30'h0, fl});
  endtask : frame

  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial begin
    srst = 1'b1;
    endpoint_mode = 1'b0;
    req = '0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    load_en = 1'b0;
    load = '0;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    rreg(16'hD024, 32'h0000_0001);
    rreg(16'hD02C, 32'h0000_0000);
    rreg(16'hD034, 32'h0000_00DC);
    rreg(16'hD03C, 32'h0A02_0100);
    rreg(16'hD040, 32'h0000_8080);
    rreg(16'hD080, 32'h0000_0000);
    note("reset");
    wreg(16'hD024, 32'hFFFF_FFFE);
    rreg(16'hD024, 32'hFFFF_FF01);
    chk("io_base_hi", 32'h0000_00FF, {24'h0, io_base_hi});
    wreg(16'hD02C, 32'hFFFF_FFFF);
    rreg(16'hD02C, 32'h0000_0000);
    wreg(16'hD034, 32'h0000_0000);
    rreg(16'hD034, 32'h0000_00DC);
    wreg(16'hD03C, 32'h5555_55A5);
    rreg(16'hD03C, 32'h0A02_01A5);
    rreg(16'hD0F0, 32'h0000_0000);
    cfg(8'h24, 32'hFFFF_FF01);
    cfg(8'h34, 32'h0000_00DC);
    note("access");
    for (i = 0; i < 5; i++) begin
      eeprom(32'h1234_5678, 8'h00, 8'hFF, i[7:0]);
      rreg(16'hD03C, {8'h00, 8'hFF, i[7:0], 8'hA5});
    end
    rreg(16'hD02C, 32'h1234_5678);
    cfg(8'h2C, 32'h1234_5678);
    note("preload");
    @(posedge ref_clk);
    endpoint_mode <= 1'b1;
    acc(1'b0, 16'hD02C, 32'h0, 2'b10, 32'h0);
    acc(1'b0, 16'hD03C, 32'h0, 2'b10, 32'h0);
    acc(1'b1, 16'hD040, 32'h0, 2'b10, 32'h0);
    rreg(16'hD024, 32'hFFFF_FF01);
    cfg(8'h3C, 32'h00FF_04A5);
    @(posedge ref_clk);
    endpoint_mode <= 1'b0;
    rreg(16'hD040, 32'h0000_8080);
    note("endpoint");
    wreg(16'hD040, 32'h0000_0304);
    rreg(16'hD040, 32'h0000_0304);
    frame(3, 0, 2'b00, 0);
    frame(4, 0, 2'b01, 1);
    frame(0, 2, 2'b01, 1);
    wreg(16'hD080, 32'h0000_0001);
    frame(0, 8, 2'b10, 2);
    wreg(16'hD080, 32'h0000_0002);
    rreg(16'hD080, 32'h0000_0000);
    wreg(16'hD040, 32'h0000_0000);
    frame(8, 8, 2'b00, 2);
    note("timeouts");
    stop_test();
  end
endmodule : tb_pch_header_regs
